// [qec_top.sv]
/*
  qec_top: quadrature encoder counter with APB registers, two latches,
  compare, reference and index logic, and a masked interrupt.
  assumes: one 25 MHz clock, synchronous active-low reset, APB master.
*/
// The implementer's own choices: the APB slave port and the placing of the registers.
// Operation
// - count x1, x2 or x4 per period
// - phase order sets count direction
// - hysteresis drops first pulse after reversal
// - two 32-bit latches, synchronised strobes
// - mode register written and read back
// - strobe from pins or register write
// - external strobe raises interrupt flag
// - reference input clears count, readable
// - one 32-bit or two 16-bit encoders
// - third input is index in 32-bit
// - fourth input is fault in 32-bit
module qec_top #(
  parameter int CNT_W = 32
) (
  // clock and reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        RSTN_I,
  // apb slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // encoder pins
  input  wire logic        ENC_A_I,
  input  wire logic        ENC_B_I,
  input  wire logic        ENC_C_I,
  input  wire logic        ENC_D_I,
  input  wire logic        REF_IN_I,
  input  wire logic        CAPTURE_TRIG_FIRST_I,
  input  wire logic        CAPTURE_TRIG_SECOND_I,
  // outputs
  output logic             AUX_OUT_O,
  output logic             IRQ_O
);
  logic [qec_pkg::MODE_W-1:0] mode_r;
  logic [qec_pkg::EV_W-1:0]   stat_r;
  logic [qec_pkg::EV_W-1:0]   stat_nxt;
  logic [qec_pkg::EV_W-1:0]   mask_r;
  logic [qec_pkg::EV_W-1:0]   mask_nxt;
  logic [CNT_W-1:0]           cmp_r;
  logic [CNT_W-1:0]           cnt_r;
  logic [CNT_W-1:0]           cnt_nxt;
  logic [CNT_W-1:0]           latch0_r;
  logic [CNT_W-1:0]           latch1_r;
  logic                       aux_r;
  logic                       sw_strb0;
  logic                       sw_strb1;
  logic                       wr_en;
  logic                       rd_en;
  logic                       dual;

  assign dual  = mode_r[qec_pkg::MODE_DUAL16];
  assign wr_en = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd_en = PSEL_I && !PENABLE_I && !PWRITE_I;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  // pin synchronisers for the level inputs c, d, ref and strobes
  localparam int NSYNC = 5;
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] lvl_r;
  logic [NSYNC-1:0] rise;
  logic [NSYNC-1:0] lvl_nxt;
  assign raw = {CAPTURE_TRIG_SECOND_I, CAPTURE_TRIG_FIRST_I, REF_IN_I, ENC_D_I, ENC_C_I};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      logic [2:0] s_r;
      always_ff @(posedge SYS_CLK_I) begin
        if (!RSTN_I) begin
          s_r <= 3'h0;
        end else begin
          s_r <= {s_r[1:0], raw[gi]};
        end
      end
      assign lvl_nxt[gi] = (s_r[1] == s_r[2]) ? s_r[2] : lvl_r[gi];
      assign rise[gi]    = lvl_nxt[gi] && !lvl_r[gi];
    end
  endgenerate

  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      lvl_r <= '0;
    end else begin
      lvl_r <= lvl_nxt;
    end
  end

  logic idx_rise;
  logic flt_rise;
  logic ref_rise;
  logic strb_a;
  logic strb_b;
  assign idx_rise = rise[0] && !dual;
  assign flt_rise = rise[1] && !dual;
  assign ref_rise = rise[2];
  assign strb_a   = rise[3];
  assign strb_b   = rise[4];

  // channel 0 on a/b; channel 1 on c/d only in dual 16-bit mode
  logic up0;
  logic dn0;
  logic up1;
  logic dn1;
  qec_decode u_dec0 (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RSTN_I),
    .a_i     (ENC_A_I),
    .b_i     (ENC_B_I),
    .eval_i  (mode_r[qec_pkg::MODE_EVAL_LSB +: 2]),
    .hyst_i  (mode_r[qec_pkg::MODE_HYST]),
    .up_o    (up0),
    .dn_o    (dn0)
  );
  qec_decode u_dec1 (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RSTN_I),
    .a_i     (ENC_C_I),
    .b_i     (ENC_D_I),
    .eval_i  (mode_r[qec_pkg::MODE_EVAL_LSB +: 2]),
    .hyst_i  (mode_r[qec_pkg::MODE_HYST]),
    .up_o    (up1),
    .dn_o    (dn1)
  );

  // the two 16-bit halves wrap on their own, so no carry crosses them
  localparam int HALF = CNT_W / 2;
  always_comb begin
    cnt_nxt = cnt_r;
    if (dual) begin
      if (up0) cnt_nxt[HALF-1:0] = cnt_r[HALF-1:0] + 1'b1;
      if (dn0) cnt_nxt[HALF-1:0] = cnt_r[HALF-1:0] - 1'b1;
      if (up1) cnt_nxt[CNT_W-1:HALF] = cnt_r[CNT_W-1:HALF] + 1'b1;
      if (dn1) cnt_nxt[CNT_W-1:HALF] = cnt_r[CNT_W-1:HALF] - 1'b1;
    end else begin
      if (up0) cnt_nxt = cnt_r + 1'b1;
      if (dn0) cnt_nxt = cnt_r - 1'b1;
    end
    if (ref_rise && mode_r[qec_pkg::MODE_REF_CLR]) cnt_nxt = '0;
    if (idx_rise && mode_r[qec_pkg::MODE_IDX_CLR]) cnt_nxt = '0;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      cnt_r <= '0;
    end else if (wr_en && hit(PADDR_I, qec_pkg::ADDR_CNT)) begin
      cnt_r <= PWDATA_I[CNT_W-1:0];
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // latch strobes: each latch picks pin or register write
  assign sw_strb0 = wr_en && hit(PADDR_I, qec_pkg::ADDR_SWSTRB) && PWDATA_I[0];
  assign sw_strb1 = wr_en && hit(PADDR_I, qec_pkg::ADDR_SWSTRB) && PWDATA_I[1];

  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      latch0_r <= '0;
    end else if (mode_r[qec_pkg::MODE_L0_EXT] ? strb_a : sw_strb0) begin
      latch0_r <= cnt_r;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      latch1_r <= '0;
    end else if (mode_r[qec_pkg::MODE_L1_EXT] ? strb_b : sw_strb1) begin
      latch1_r <= cnt_r;
    end
  end

  // control registers, one process each; a write lands at the access edge
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      mode_r <= qec_pkg::MODE_RST;
    end else if (wr_en && hit(PADDR_I, qec_pkg::ADDR_MODE)) begin
      mode_r <= PWDATA_I[qec_pkg::MODE_W-1:0];
    end
  end

  // irq looks at the mask being written, so a mask write acts at once
  assign mask_nxt = (wr_en && hit(PADDR_I, qec_pkg::ADDR_MASK)) ?
                    PWDATA_I[qec_pkg::EV_W-1:0] : mask_r;
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      mask_r <= '0;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      cmp_r <= '0;
    end else if (wr_en && hit(PADDR_I, qec_pkg::ADDR_CMP)) begin
      cmp_r <= PWDATA_I[CNT_W-1:0];
    end
  end

  // the pin copy moves with the register, so the pin never lags a write
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      aux_r     <= 1'b0;
      AUX_OUT_O <= 1'b0;
    end else if (wr_en && hit(PADDR_I, qec_pkg::ADDR_OUT)) begin
      aux_r     <= PWDATA_I[0];
      AUX_OUT_O <= PWDATA_I[0];
    end
  end

  // compare fires on the cycle the count becomes equal
  logic cmp_hit;
  // a preset write overrides the count, so it must not raise a match
  assign cmp_hit = (cnt_nxt == cmp_r) && (cnt_nxt != cnt_r) &&
                   !(wr_en && hit(PADDR_I, qec_pkg::ADDR_CNT));

  logic [qec_pkg::EV_W-1:0] ev;
  always_comb begin
    ev = '0;
    ev[qec_pkg::EV_STRB_A] = strb_a;
    ev[qec_pkg::EV_STRB_B] = strb_b;
    ev[qec_pkg::EV_CMP]    = cmp_hit;
    ev[qec_pkg::EV_REF]    = ref_rise;
    ev[qec_pkg::EV_FAULT]  = flt_rise;
    ev[qec_pkg::EV_INDEX]  = idx_rise;
  end

  // write one to clear; a new event in the same cycle wins
  always_comb begin
    stat_nxt = stat_r;
    if (wr_en && hit(PADDR_I, qec_pkg::ADDR_STAT)) begin
      stat_nxt = stat_r & ~PWDATA_I[qec_pkg::EV_W-1:0];
    end
    stat_nxt = stat_nxt | ev;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      stat_r <= '0;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(stat_nxt & mask_nxt);
    end
  end

  // read data captured in setup, so each access takes exactly two cycles
  logic known;
  always_comb begin
    unique case (PADDR_I)
      qec_pkg::ADDR_MODE, qec_pkg::ADDR_STAT, qec_pkg::ADDR_MASK,
      qec_pkg::ADDR_CMP, qec_pkg::ADDR_CNT, qec_pkg::ADDR_LATCH0,
      qec_pkg::ADDR_LATCH1, qec_pkg::ADDR_SWSTRB, qec_pkg::ADDR_PINS,
      qec_pkg::ADDR_OUT: known = 1'b1;
      default:           known = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      PRDATA_O <= 32'h0;
    end else if (rd_en) begin
      PRDATA_O <= 32'h0;
      if (hit(PADDR_I, qec_pkg::ADDR_MODE))   PRDATA_O[qec_pkg::MODE_W-1:0] <= mode_r;
      if (hit(PADDR_I, qec_pkg::ADDR_STAT))   PRDATA_O[qec_pkg::EV_W-1:0] <= stat_r;
      if (hit(PADDR_I, qec_pkg::ADDR_MASK))   PRDATA_O[qec_pkg::EV_W-1:0] <= mask_r;
      if (hit(PADDR_I, qec_pkg::ADDR_CMP))    PRDATA_O[CNT_W-1:0] <= cmp_r;
      if (hit(PADDR_I, qec_pkg::ADDR_CNT))    PRDATA_O[CNT_W-1:0] <= cnt_r;
      if (hit(PADDR_I, qec_pkg::ADDR_LATCH0)) PRDATA_O[CNT_W-1:0] <= latch0_r;
      if (hit(PADDR_I, qec_pkg::ADDR_LATCH1)) PRDATA_O[CNT_W-1:0] <= latch1_r;
      if (hit(PADDR_I, qec_pkg::ADDR_PINS))   PRDATA_O[NSYNC-1:0] <= lvl_r;
      if (hit(PADDR_I, qec_pkg::ADDR_OUT))    PRDATA_O[0] <= aux_r;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O  <= PSEL_I && !PENABLE_I;
      PSLVERR_O <= PSEL_I && !PENABLE_I && !known;
    end
  end
endmodule

// [qec_pkg.sv]
/*
  qec_pkg: register offsets, field positions, reset values and event bits
  of the quadrature encoder counter.
  assumes: used by qec_top and qec_decode through qec_pkg::name only.
*/
package qec_pkg;
  localparam logic [7:0]  ADDR_MODE   = 8'h00;
  localparam logic [7:0]  ADDR_STAT   = 8'h04;
  localparam logic [7:0]  ADDR_MASK   = 8'h08;
  localparam logic [7:0]  ADDR_CMP    = 8'h0c;
  localparam logic [7:0]  ADDR_CNT    = 8'h10;
  localparam logic [7:0]  ADDR_LATCH0 = 8'h14;
  localparam logic [7:0]  ADDR_LATCH1 = 8'h18;
  localparam logic [7:0]  ADDR_SWSTRB = 8'h1c;
  localparam logic [7:0]  ADDR_PINS   = 8'h20;
  localparam logic [7:0]  ADDR_OUT    = 8'h24;

  // mode register fields
  localparam int MODE_EVAL_LSB = 0;  // 2 bits: 0 single, 1 double, 2 quad
  localparam int MODE_HYST     = 2;
  localparam int MODE_DUAL16   = 3;
  localparam int MODE_L0_EXT   = 4;
  localparam int MODE_L1_EXT   = 5;
  localparam int MODE_REF_CLR  = 6;
  localparam int MODE_IDX_CLR  = 7;
  localparam int MODE_W        = 8;
  localparam logic [7:0] MODE_RST = 8'h02;

  // status bits, also mask layout
  localparam int EV_STRB_A = 0;
  localparam int EV_STRB_B = 1;
  localparam int EV_CMP    = 2;
  localparam int EV_REF    = 3;
  localparam int EV_FAULT  = 4;
  localparam int EV_INDEX  = 5;
  localparam int EV_W      = 6;

  localparam logic [1:0] EVAL_X1 = 2'h0;
  localparam logic [1:0] EVAL_X2 = 2'h1;
  localparam logic [1:0] EVAL_X4 = 2'h2;
endpackage

// [qec_decode.sv]
/*
  qec_decode: one quadrature channel, three flop synchroniser, x1/x2/x4
  evaluation, direction detect and reversal hysteresis.
  assumes: a and b are raw pins; outputs are one-cycle count pulses.
*/
module qec_decode (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // pins and setup
  input  wire logic       a_i,
  input  wire logic       b_i,
  input  wire logic [1:0] eval_i,
  input  wire logic       hyst_i,
  // count pulses
  output logic            up_o,
  output logic            dn_o
);
  logic [2:0] a_sync_r;
  logic [2:0] b_sync_r;
  logic       a_r;
  logic       b_r;
  logic       dir_r;
  logic       dir_valid_r;
  logic       step;
  logic       fwd;
  logic       take;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      a_sync_r <= 3'h0;
      b_sync_r <= 3'h0;
    end else begin
      a_sync_r <= {a_sync_r[1:0], a_i};
      b_sync_r <= {b_sync_r[1:0], b_i};
    end
  end

  // a change counts once the second and third stage agree
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      a_r <= 1'b0;
      b_r <= 1'b0;
    end else begin
      if (a_sync_r[1] == a_sync_r[2]) a_r <= a_sync_r[2];
      if (b_sync_r[1] == b_sync_r[2]) b_r <= b_sync_r[2];
    end
  end

  logic a_new;
  logic b_new;
  assign a_new = (a_sync_r[1] == a_sync_r[2]) ? a_sync_r[2] : a_r;
  assign b_new = (b_sync_r[1] == b_sync_r[2]) ? b_sync_r[2] : b_r;

  // a leads b: forward; a simultaneous change of both is dropped
  always_comb begin
    step = 1'b0;
    fwd  = 1'b0;
    if ((a_new != a_r) && (b_new == b_r)) begin
      fwd  = (a_new != b_r);
      // x1 takes the a edges made while b is low: one per period either way
      step = (eval_i == qec_pkg::EVAL_X4) || (eval_i == qec_pkg::EVAL_X2) ||
             ((eval_i == qec_pkg::EVAL_X1) && !b_r);
    end else if ((b_new != b_r) && (a_new == a_r)) begin
      fwd  = (b_new == a_r);
      step = (eval_i == qec_pkg::EVAL_X4);
    end
  end

  // first pulse after a reversal is absorbed when hysteresis is on
  assign take = step && !(hyst_i && dir_valid_r && (fwd != dir_r));

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dir_r       <= 1'b0;
      dir_valid_r <= 1'b0;
    end else if (step) begin
      dir_r       <= fwd;
      dir_valid_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      up_o <= 1'b0;
      dn_o <= 1'b0;
    end else begin
      up_o <= take && fwd;
      dn_o <= take && !fwd;
    end
  end
endmodule

// [qec_chk_sva.sv]
/*
  qec_chk_sva: bus and interrupt checks on the counter's pins.
  assumes: bound to qec_top; one clock, sync active-low reset.
*/
module qec_chk_sva #(
  parameter int CNT_W = 32
) (
  // clock and reset
  input wire logic        SYS_CLK_I,
  input wire logic        RSTN_I,
  // apb
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  // outputs
  input wire logic        AUX_OUT_O,
  input wire logic        IRQ_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RSTN_I);
  // unmapped: past the last register or not word aligned
  logic bad_addr;
  assign bad_addr = (PADDR_I > qec_pkg::ADDR_OUT) || (PADDR_I[1:0] != 2'h0);
  sequence setup_s;
    PSEL_I && !PENABLE_I;
  endsequence
  ready_after_setup_a: assert property (setup_s |=> PREADY_O)
    else $error("no ready after setup");
  ready_one_cycle_a: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready too long");
  ready_needs_setup_a: assert property (!(PSEL_I && !PENABLE_I) |=> !PREADY_O)
    else $error("ready without setup");
  unmapped_err_a: assert property (setup_s ##0 bad_addr |=> PSLVERR_O)
    else $error("no error on unmapped");
  mapped_ok_a: assert property (setup_s ##0 !bad_addr |=> !PSLVERR_O)
    else $error("error on mapped");
  rdata_hold_a: assert property (!(PSEL_I && !PENABLE_I) |=> $stable(PRDATA_O))
    else $error("read data moved");
  aux_hold_a: assert property (!(PSEL_I && PENABLE_I && PWRITE_I) |=> $stable(AUX_OUT_O))
    else $error("aux moved without write");
  irq_clear_a: assert property ($fell(IRQ_O) |-> $past(PSEL_I && PENABLE_I && PWRITE_I))
    else $error("irq fell without write");
  reset_quiet_a: assert property (disable iff (1'b0) !RSTN_I |=> !IRQ_O && !PREADY_O)
    else $error("outputs active in reset");
endmodule

// [qec_enc_model.sv]
/*
  qec_enc_model: incremental encoder, one gray step per request.
  assumes: step_i is a one-cycle request spaced well apart.
*/
module qec_enc_model (
  // control
  input  wire logic clk_i,
  input  wire logic step_i,
  input  wire logic dir_i,
  // encoder lines
  output logic      a_o,
  output logic      b_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ph_r = 2'h0;
  // one line changes per step, so no simultaneous edges reach the decoder
  always_ff @(posedge clk_i) begin
    if (step_i) ph_r <= dir_i ? ph_r + 2'h1 : ph_r - 2'h1;
  end
  assign a_o = ph_r[1] ^ ph_r[0];
  assign b_o = ph_r[1];
endmodule

// [tb_top.sv]
/*
  tb_top: apb regression of the encoder counter.
  assumes: qec_pkg, qec_top, qec_enc_model, qec_chk_sva compiled first.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  pin_r = 5'h00;
  logic [1:0]  stp_r = 2'h0;
  logic        dir_r = 1'b1;
  logic        a0, b0, a1, b1, aux, irq, er;
  logic [31:0] rd;
  int          fail_count = 0;
  int          tests_run = 0;
  qec_enc_model qec_enc_model_inst (.clk_i(clk), .step_i(stp_r[0]), .dir_i(dir_r),
    .a_o(a0), .b_o(b0));
  qec_enc_model qec_enc_model_inst_1 (.clk_i(clk), .step_i(stp_r[1]), .dir_i(dir_r),
    .a_o(a1), .b_o(b1));
  qec_top qec_top_inst (.SYS_CLK_I(clk), .RSTN_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .ENC_A_I(a0), .ENC_B_I(b0),
    .ENC_C_I(a1 | pin_r[3]), .ENC_D_I(b1 | pin_r[4]), .REF_IN_I(pin_r[2]),
    .CAPTURE_TRIG_FIRST_I(pin_r[0]), .CAPTURE_TRIG_SECOND_I(pin_r[1]),
    .AUX_OUT_O(aux), .IRQ_O(irq));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] v);
    tests_run++;
    if (v !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, v);
    end
  endtask
  // setup, access, then hold until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge clk);
    end
    if (n == 16) fail_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp($sformatf("reg %h", a), e, rd);
  endtask
  task automatic stat(input logic [31:0] e);
    chk(8'h04, e);
    wr(8'h04, 32'h3f);
  endtask
  // eight cycles a level, well above the three the sync needs
  task automatic steps(input int n, input logic up, input int ch);
    dir_r <= up;
    repeat (n) begin
      @(posedge clk);
      stp_r[ch] <= 1'b1;
      @(posedge clk);
      stp_r[ch] <= 1'b0;
      repeat (6) @(posedge clk);
    end
    repeat (8) @(posedge clk);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    pin_r[i] <= 1'b1;
    repeat (8) @(posedge clk);
    pin_r[i] <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    chk(8'h00, 32'h02);
    for (int e = 0; e < 3; e++) begin
      wr(8'h00, 32'(e));
      wr(8'h10, 32'h0);
      steps(8, 1'b1, 0);
      chk(8'h10, 32'h2 << e);
    end
    wr(8'h00, 32'h06);
    chk(8'h00, 32'h06);
    wr(8'h10, 32'h0);
    steps(4, 1'b0, 0);
    chk(8'h10, 32'hfffffffd);
    wr(8'h00, 32'h02);
    steps(4, 1'b1, 0);
    chk(8'h10, 32'h1);
    wr(8'h00, 32'h00);
    wr(8'h10, 32'h0);
    steps(8, 1'b0, 0);
    chk(8'h10, 32'hfffffffe);
    wr(8'h00, 32'h02);
    wr(8'h0c, 32'h5);
    wr(8'h10, 32'h0);
    wr(8'h04, 32'h3f);
    steps(6, 1'b1, 0);
    stat(32'h04);
    wr(8'h10, 32'h1234abcd);
    wr(8'h1c, 32'h3);
    chk(8'h14, 32'h1234abcd);
    chk(8'h18, 32'h1234abcd);
    chk(8'h1c, 32'h0);
    wr(8'h00, 32'h32);
    wr(8'h10, 32'h55);
    pulse(0);
    wr(8'h10, 32'h66);
    pulse(1);
    chk(8'h14, 32'h55);
    chk(8'h18, 32'h66);
    wr(8'h08, 32'h01);
    repeat (2) @(posedge clk);
    cmp("irq", 32'h1, {31'h0, irq});
    wr(8'h04, 32'h01);
    repeat (2) @(posedge clk);
    cmp("irq", 32'h0, {31'h0, irq});
    stat(32'h02);
    wr(8'h00, 32'h82);
    wr(8'h10, 32'h9);
    pulse(3);
    pulse(4);
    chk(8'h10, 32'h0);
    stat(32'h30);
    wr(8'h00, 32'h42);
    wr(8'h10, 32'h9);
    @(posedge clk);
    pin_r[2] <= 1'b1;
    repeat (8) @(posedge clk);
    chk(8'h20, 32'h04);
    chk(8'h10, 32'h0);
    pin_r[2] <= 1'b0;
    stat(32'h08);
    wr(8'h00, 32'h0a);
    wr(8'h10, 32'h0);
    steps(4, 1'b1, 1);
    steps(3, 1'b1, 0);
    chk(8'h10, 32'h00040003);
    wr(8'h24, 32'h1);
    repeat (2) @(posedge clk);
    cmp("aux", 32'h1, {31'h0, aux});
    apb(1'b0, 8'h40, 32'h0);
    cmp("slverr", 32'h1, {31'h0, er});
    cmp("rdata", 32'h0, rd);
    report_and_stop();
  end
endmodule
bind qec_top qec_chk_sva #(.CNT_W(CNT_W)) qec_chk_sva_inst (.SYS_CLK_I, .RSTN_I, .PSEL_I,
  .PENABLE_I, .PWRITE_I, .PADDR_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .AUX_OUT_O, .IRQ_O);
